// File: mcs_regs.svh
// Offsets, field positions, reset values and timing counts of the module control and status block.
// Assumes a 100 MHz core clock and byte-wide registers on the plain register port.
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// ==========================================================================
// Timing
`define MCS_CLK_KHZ          100000
`define MCS_T_RESET_MIN_US   2
`define MCS_T_INIT_MS        2000
`define MCS_RESET_MIN_CYC    ((`MCS_T_RESET_MIN_US * `MCS_CLK_KHZ + 999) / 1000)
`define MCS_INIT_CYC         (`MCS_T_INIT_MS * `MCS_CLK_KHZ)

// ==========================================================================
// Register offsets
`define MCS_ADDR_STATUS      8'h02
`define MCS_ADDR_FLAG_LOS    8'h03
`define MCS_ADDR_FLAG_TXF    8'h04
`define MCS_ADDR_FLAG_OTHER  8'h05
`define MCS_ADDR_RATE_SEL    8'h57
`define MCS_ADDR_POWER_CTRL  8'h5D
`define MCS_ADDR_MASK_LOS    8'h64
`define MCS_ADDR_MASK_TXF    8'h65
`define MCS_ADDR_MASK_OTHER  8'h66

// ==========================================================================
// Field positions and reset values
`define MCS_DNR_BIT          0
`define MCS_PDOWN_BIT        0
`define MCS_FLAG_GROUPS      3
`define MCS_RST_MASK         8'h00
`define MCS_RST_CTRL         8'h00

`endif

// File: mcs_pkg.sv
// Types shared by the module control and status block.
// Assumes nothing of its surroundings.
`default_nettype none

package mcs_pkg;

	// ======================================================================
	// Fault and event conditions from the optical and electrical front end.
	typedef struct packed {
		logic       other;
		logic [3:0] tx_fault;
		logic [3:0] los;
	} mcs_cond_t;

	// ======================================================================
	// Initialisation sequence.
	typedef enum logic [1:0] {
		MCS_ST_HOLD  = 2'b00,
		MCS_ST_INIT  = 2'b01,
		MCS_ST_READY = 2'b10
	} mcs_state_t;

endpackage

`default_nettype wire

// File: mcs_ctrl.sv
// Module control and status logic: reset pin filter, initialisation timer, latched flags with masks,
// interrupt output, low-power control and rate select.
// Assumes the host reaches the registers over a plain byte-wide port on clk_in; pins are asynchronous.
//
// Notes on behaviour
// - Reset pin low over 2 us resets module.
// - Register port answers within 2000 ms of power.
// - Data-not-ready clears, interrupt asserts within 2000 ms.
// - Fully functional within 2000 ms after reset release.
// - Full function within 2000 ms after power/reset.
// - Low-power pin high enters power level 1.
// - Low-power pin low restores full function quickly.
// - Interrupt condition drives interrupt low within limit.
// - Clear-on-read releases interrupt within 500 us.
// - Receive loss sets flag and interrupt.
// - Transmit fault sets flag and interrupt.
// - Any other condition sets flag and interrupt.
// - Setting a mask bit inhibits its interrupt.
// - Clearing a mask bit resumes its interrupt.
// - Rate select change reaches output promptly.
// - Power-down bit set enters power level 1.
// - Power-down bit cleared restores full function.
// - Fully functional once ready interrupt asserted.
// - Host access limits timed from access end.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "mcs_regs.svh"

module mcs_ctrl
	import mcs_pkg::*;
#(
	parameter int unsigned INIT_CYCLES  = `MCS_INIT_CYC,
	parameter int unsigned RESET_CYCLES = `MCS_RESET_MIN_CYC
) (
	input  wire logic       clk_in,                     // Core clock, 100 MHz.
	input  wire logic       reset_n_in,                 // Power-on reset, asynchronous, active low.
	input  wire logic       module_reset_n_in,          // Module reset pin, active low.
	input  wire logic       low_power_request_pin_in,   // Low-power request pin, active high.
	input  wire mcs_cond_t  cond_in,                    // Front-end fault and event conditions.
	input  wire logic [7:0] reg_addr_in,                // Register byte address.
	input  wire logic [7:0] reg_wdata_in,               // Register write data.
	input  wire logic       reg_wr_in,                  // Register write strobe.
	input  wire logic       reg_rd_in,                  // Register read strobe.
	output logic      [7:0] reg_rdata_out,              // Read data, valid the cycle after the strobe.
	output logic            module_interrupt_n_out,     // Interrupt output, active low.
	output logic            bus_ready_out,              // Register port answering.
	output logic            low_power_out,              // Power level 1 in force.
	output logic      [7:0] rate_select_out             // Rate and application select bits.
);

	// ======================================================================
	// Pin synchronisers
	localparam int SYNC_W = 11;

	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;
	logic              rst_pin_s;
	logic              lp_pin_s;
	mcs_cond_t         cond_s;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			// Each stage resets to its pin's idle level, so no false edge or condition follows reset.
			sync1_ff <= 11'h400;
			sync2_ff <= 11'h400;
		end else begin
			sync1_ff <= {module_reset_n_in, low_power_request_pin_in, cond_in};
			sync2_ff <= sync1_ff;
		end
	end

	assign rst_pin_s = sync2_ff[10];
	assign lp_pin_s  = sync2_ff[9];
	assign cond_s    = mcs_cond_t'(sync2_ff[8:0]);

	// ======================================================================
	// Reset pin filter
	logic [31:0] low_cnt_ff;
	logic        soft_rst;

	assign soft_rst = (low_cnt_ff >= RESET_CYCLES);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			low_cnt_ff <= 32'h0000_0000;
		end else if (rst_pin_s) begin
			low_cnt_ff <= 32'h0000_0000;
		end else if (!soft_rst) begin
			low_cnt_ff <= low_cnt_ff + 32'h0000_0001;
		end
	end

	// ======================================================================
	// Initialisation sequence
	mcs_state_t  state_ff;
	logic [31:0] init_cnt_ff;
	logic        ready_evt;
	logic        ready;

	assign ready_evt = (state_ff == MCS_ST_INIT) && (init_cnt_ff >= INIT_CYCLES - 1);
	assign ready     = (state_ff == MCS_ST_READY);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_ff    <= MCS_ST_INIT;
			init_cnt_ff <= 32'h0000_0000;
		end else if (soft_rst) begin
			state_ff    <= MCS_ST_HOLD;
			init_cnt_ff <= 32'h0000_0000;
		end else begin
			case (state_ff)
				MCS_ST_HOLD: begin
					state_ff    <= MCS_ST_INIT;
					init_cnt_ff <= 32'h0000_0000;
				end
				MCS_ST_INIT: begin
					if (ready_evt) begin
						state_ff <= MCS_ST_READY;
					end else begin
						init_cnt_ff <= init_cnt_ff + 32'h0000_0001;
					end
				end
				default: begin
					state_ff <= MCS_ST_READY;
				end
			endcase
		end
	end

	// ======================================================================
	// Register access decode
	logic wr_ok;
	logic rd_ok;

	assign wr_ok = reg_wr_in && ready;
	assign rd_ok = reg_rd_in && ready;

	// ======================================================================
	// Data-ready event flag, cleared by reading the status byte
	logic ready_flag_ff;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ready_flag_ff <= 1'b0;
		end else if (soft_rst) begin
			ready_flag_ff <= 1'b0;
		end else if (ready_evt) begin
			ready_flag_ff <= 1'b1;
		end else if (rd_ok && reg_addr_in == `MCS_ADDR_STATUS) begin
			ready_flag_ff <= 1'b0;
		end
	end

	// ======================================================================
	// Latched flags and masks, one group each for loss, transmit fault and other
	logic [7:0] cond_grp   [`MCS_FLAG_GROUPS];
	logic [7:0] flag_ff    [`MCS_FLAG_GROUPS];
	logic [7:0] mask_ff    [`MCS_FLAG_GROUPS];
	logic [7:0] flag_addr  [`MCS_FLAG_GROUPS];
	logic [7:0] mask_addr  [`MCS_FLAG_GROUPS];
	logic [`MCS_FLAG_GROUPS-1:0] grp_active;

	assign cond_grp[0]  = {4'h0, cond_s.los};
	assign cond_grp[1]  = {4'h0, cond_s.tx_fault};
	assign cond_grp[2]  = {7'h00, cond_s.other};
	assign flag_addr[0] = `MCS_ADDR_FLAG_LOS;
	assign flag_addr[1] = `MCS_ADDR_FLAG_TXF;
	assign flag_addr[2] = `MCS_ADDR_FLAG_OTHER;
	assign mask_addr[0] = `MCS_ADDR_MASK_LOS;
	assign mask_addr[1] = `MCS_ADDR_MASK_TXF;
	assign mask_addr[2] = `MCS_ADDR_MASK_OTHER;

	genvar g;
	generate
		for (g = 0; g < `MCS_FLAG_GROUPS; g++) begin : gen_flag
			// A condition present in the cycle of a clearing read survives the clear.
			always_ff @(posedge clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					flag_ff[g] <= 8'h00;
				end else if (soft_rst || !ready) begin
					flag_ff[g] <= 8'h00;
				end else if (rd_ok && reg_addr_in == flag_addr[g]) begin
					flag_ff[g] <= cond_grp[g];
				end else begin
					flag_ff[g] <= flag_ff[g] | cond_grp[g];
				end
			end

			always_ff @(posedge clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					mask_ff[g] <= `MCS_RST_MASK;
				end else if (soft_rst) begin
					mask_ff[g] <= `MCS_RST_MASK;
				end else if (wr_ok && reg_addr_in == mask_addr[g]) begin
					mask_ff[g] <= reg_wdata_in;
				end
			end

			assign grp_active[g] = |(flag_ff[g] & ~mask_ff[g]);
		end
	endgenerate

	// ======================================================================
	// Interrupt output
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			module_interrupt_n_out <= 1'b1;
		end else begin
			module_interrupt_n_out <= ~((|grp_active) | ready_flag_ff);
		end
	end

	// ======================================================================
	// Control registers
	logic [7:0] power_ctrl_ff;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			power_ctrl_ff <= `MCS_RST_CTRL;
		end else if (soft_rst) begin
			power_ctrl_ff <= `MCS_RST_CTRL;
		end else if (wr_ok && reg_addr_in == `MCS_ADDR_POWER_CTRL) begin
			power_ctrl_ff <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rate_select_out <= `MCS_RST_CTRL;
		end else if (soft_rst) begin
			rate_select_out <= `MCS_RST_CTRL;
		end else if (wr_ok && reg_addr_in == `MCS_ADDR_RATE_SEL) begin
			rate_select_out <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			low_power_out <= 1'b0;
		end else begin
			low_power_out <= lp_pin_s | power_ctrl_ff[`MCS_PDOWN_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bus_ready_out <= 1'b0;
		end else begin
			bus_ready_out <= (ready_evt | ready) && !soft_rst;
		end
	end

	// ======================================================================
	// Read data
	logic [7:0] nxt_rdata;

	always_comb begin
		nxt_rdata = 8'h00;
		if (!rd_ok) begin
			nxt_rdata = 8'h00;
		end else if (reg_addr_in == `MCS_ADDR_STATUS) begin
			nxt_rdata = {7'h00, !ready};
		end else if (reg_addr_in == `MCS_ADDR_FLAG_LOS) begin
			nxt_rdata = flag_ff[0];
		end else if (reg_addr_in == `MCS_ADDR_FLAG_TXF) begin
			nxt_rdata = flag_ff[1];
		end else if (reg_addr_in == `MCS_ADDR_FLAG_OTHER) begin
			nxt_rdata = flag_ff[2];
		end else if (reg_addr_in == `MCS_ADDR_MASK_LOS) begin
			nxt_rdata = mask_ff[0];
		end else if (reg_addr_in == `MCS_ADDR_MASK_TXF) begin
			nxt_rdata = mask_ff[1];
		end else if (reg_addr_in == `MCS_ADDR_MASK_OTHER) begin
			nxt_rdata = mask_ff[2];
		end else if (reg_addr_in == `MCS_ADDR_POWER_CTRL) begin
			nxt_rdata = power_ctrl_ff;
		end else if (reg_addr_in == `MCS_ADDR_RATE_SEL) begin
			nxt_rdata = rate_select_out;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= 8'h00;
		end else begin
			reg_rdata_out <= nxt_rdata;
		end
	end

	// ======================================================================
	// Assertions
	localparam int FLAG_LAT = 4;

	a_reset_filter_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(!rst_pin_s && low_cnt_ff == RESET_CYCLES - 1) |-> ##2 (state_ff == MCS_ST_HOLD))
		else $error("long reset pulse did not reset the module");

	a_short_pulse_kept: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(ready && !soft_rst && rst_pin_s) |=> ready)
		else $error("module left ready without a long reset pulse");

	a_init_bounded: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(state_ff == MCS_ST_INIT && init_cnt_ff == INIT_CYCLES - 1 && !soft_rst) |=> (ready && bus_ready_out))
		else $error("initialisation overran its limit");

	a_ready_interrupt: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(ready_evt && !soft_rst) |-> ##2 !module_interrupt_n_out)
		else $error("data ready did not raise the interrupt");

	a_bus_silent: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_rd_in && !ready) |=> (reg_rdata_out == 8'h00))
		else $error("register port answered before ready");

	a_flag_to_int: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(ready && !soft_rst && |(cond_s.los & ~mask_ff[0][3:0]) && !reg_wr_in)
		|-> ##[1:FLAG_LAT] !module_interrupt_n_out)
		else $error("unmasked loss did not assert the interrupt");

	a_masked_quiet: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(!ready_flag_ff && grp_active == 3'b000) |=> module_interrupt_n_out)
		else $error("interrupt asserted with all flags masked or clear");

	a_clear_release: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(rd_ok && reg_addr_in == `MCS_ADDR_FLAG_OTHER && !cond_s.other) |=> (flag_ff[2] == 8'h00))
		else $error("read did not clear the flag");

	a_low_power_pin: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(lp_pin_s) |=> low_power_out)
		else $error("low-power pin did not enter power level 1");

	a_pdown_follow: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(!lp_pin_s && !power_ctrl_ff[`MCS_PDOWN_BIT]) |=> !low_power_out)
		else $error("module stayed in low power");

	a_rate_select: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(wr_ok && !soft_rst && reg_addr_in == `MCS_ADDR_RATE_SEL) |=> (rate_select_out == $past(reg_wdata_in)))
		else $error("rate select not applied");

	c_ready_reached: cover property (@(posedge clk_in) disable iff (!reset_n_in) ready_evt);
	c_flag_cleared: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		!module_interrupt_n_out ##1 rd_ok ##[1:4] module_interrupt_n_out);
	c_soft_reset: cover property (@(posedge clk_in) disable iff (!reset_n_in) $rose(soft_rst));
	c_power_down: cover property (@(posedge clk_in) disable iff (!reset_n_in) $rose(low_power_out));

endmodule

`default_nettype wire

// File: mcs_host_model.sv
// Host controller model: drives the register port and the module reset pin.
// Assumes the core clock of the block under test; requests change right after a rising edge.
`timescale 1ns/100ps
`default_nettype none

module mcs_host_model (
	input  wire logic       clk_in,              // Core clock.
	input  wire logic [7:0] reg_rdata_in,        // Read data from the block.
	output var  logic [7:0] reg_addr_out,        // Register address.
	output var  logic [7:0] reg_wdata_out,       // Write data.
	output var  logic       reg_wr_out,          // Write strobe.
	output var  logic       reg_rd_out,          // Read strobe.
	output var  logic       module_reset_n_out   // Module reset pin, active low.
);
	initial begin
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
		reg_wr_out = 1'h0;
		reg_rd_out = 1'h0;
		module_reset_n_out = 1'h1;
	end

	// Released address and data are inverted so a stale value never passes for a live one.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_wr_out <= 1'h1;
		reg_addr_out <= a;
		reg_wdata_out <= d;
		@(posedge clk_in);
		reg_wr_out <= 1'h0;
		reg_addr_out <= ~a;
		reg_wdata_out <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		reg_rd_out <= 1'h1;
		reg_addr_out <= a;
		@(posedge clk_in);
		reg_rd_out <= 1'h0;
		reg_addr_out <= ~a;
		@(negedge clk_in);
		d = reg_rdata_in;
	endtask

	task automatic pulse_rst(input int n);
		@(posedge clk_in);
		module_reset_n_out <= 1'h0;
		repeat (n) @(posedge clk_in);
		module_reset_n_out <= 1'h1;
	endtask
endmodule

`default_nettype wire

// File: module_control_status_timing_tb.sv
// Testbench for the module control and status block, with a host model on the register port.
// Assumes short timing parameters: 50 cycles of initialisation, 20 cycles of reset filter.
`timescale 1ns/100ps
`default_nettype none

module module_control_status_timing_tb;
	import mcs_pkg::*;

	logic       clk_in;
	logic       reset_n_in;
	logic       lp_pin;
	mcs_cond_t  cond;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic       mrst_n;
	logic [7:0] rdata;
	logic       int_n;
	logic       ready;
	logic       lowp;
	logic [7:0] rate;
	int         num_checks;
	int         miscompares;

	mcs_ctrl #(.INIT_CYCLES(50), .RESET_CYCLES(20)) i_mcs_ctrl (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .module_reset_n_in(mrst_n),
		.low_power_request_pin_in(lp_pin), .cond_in(cond), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.module_interrupt_n_out(int_n), .bus_ready_out(ready), .low_power_out(lowp),
		.rate_select_out(rate));

	mcs_host_model i_mcs_host_model (
		.clk_in(clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr), .reg_wdata_out(wdata),
		.reg_wr_out(wr), .reg_rd_out(rd), .module_reset_n_out(mrst_n));

	initial begin
		clk_in = 1'h0;
		forever #5 clk_in = ~clk_in;
	end

	// ======================================================================
	// Checking helpers
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return int_n;
			1: return ready;
			default: return lowp;
		endcase
	endfunction

	task automatic wt(input int s, input logic v);
		for (int i = 0; i < 100 && sig(s) !== v; i++)
			@(negedge clk_in);
		chk("wait", {7'h00, v}, {7'h00, sig(s)});
		if (sig(s) !== v)
			complete_run();
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_mcs_host_model.rd(a, d);
		chk("read", e, d);
	endtask

	// ======================================================================
	// Scenarios
	task automatic t_start();
		wt(1, 1'h1);
		wt(0, 1'h0);
		rchk(8'h02, 8'h00);
		wt(0, 1'h1);
	endtask

	task automatic t_flags();
		@(posedge clk_in);
		cond.los <= 4'h4;
		cond.tx_fault <= 4'h2;
		wt(0, 1'h0);
		repeat (6) @(posedge clk_in);
		cond <= 9'h000;
		repeat (6) @(posedge clk_in);
		rchk(8'h03, 8'h04);
		repeat (6) @(negedge clk_in);
		chk("int held", 8'h00, {7'h00, int_n});
		rchk(8'h04, 8'h02);
		wt(0, 1'h1);
		rchk(8'h03, 8'h00);
		@(posedge clk_in);
		cond.other <= 1'h1;
		wt(0, 1'h0);
		@(posedge clk_in);
		cond.other <= 1'h0;
		repeat (6) @(posedge clk_in);
		rchk(8'h05, 8'h01);
		wt(0, 1'h1);
	endtask

	task automatic t_mask();
		i_mcs_host_model.wr(8'h64, 8'h01);
		cond.los <= 4'h1;
		repeat (10) @(negedge clk_in);
		chk("masked int", 8'h01, {7'h00, int_n});
		@(posedge clk_in);
		cond.los <= 4'h0;
		i_mcs_host_model.wr(8'h65, 8'h0F);
		rchk(8'h65, 8'h0F);
		i_mcs_host_model.wr(8'h66, 8'h01);
		rchk(8'h66, 8'h01);
		i_mcs_host_model.wr(8'h64, 8'h00);
		wt(0, 1'h0);
		rchk(8'h03, 8'h01);
		wt(0, 1'h1);
	endtask

	task automatic t_power();
		@(posedge clk_in);
		lp_pin <= 1'h1;
		wt(2, 1'h1);
		@(posedge clk_in);
		lp_pin <= 1'h0;
		wt(2, 1'h0);
		i_mcs_host_model.wr(8'h5D, 8'h01);
		wt(2, 1'h1);
		rchk(8'h5D, 8'h01);
		i_mcs_host_model.wr(8'h5D, 8'h00);
		wt(2, 1'h0);
	endtask

	task automatic t_rate();
		i_mcs_host_model.wr(8'h57, 8'hA5);
		@(negedge clk_in);
		chk("rate", 8'hA5, rate);
		rchk(8'h57, 8'hA5);
		i_mcs_host_model.wr(8'h40, 8'hFF);
		rchk(8'h40, 8'h00);
	endtask

	task automatic t_reset();
		i_mcs_host_model.pulse_rst(10);
		repeat (30) @(negedge clk_in);
		chk("short reset", 8'h01, {7'h00, ready});
		rchk(8'h57, 8'hA5);
		i_mcs_host_model.pulse_rst(25);
		@(negedge clk_in);
		chk("long reset", 8'h00, {7'h00, ready});
		wt(1, 1'h1);
		wt(0, 1'h0);
		rchk(8'h57, 8'h00);
		rchk(8'h65, 8'h00);
		rchk(8'h66, 8'h00);
		rchk(8'h02, 8'h00);
		wt(0, 1'h1);
	endtask

	initial begin
		num_checks = 0;
		miscompares = 0;
		reset_n_in = 1'h0;
		lp_pin = 1'h0;
		cond = 9'h000;
		repeat (5) @(posedge clk_in);
		reset_n_in <= 1'h1;
		t_start();
		t_flags();
		t_mask();
		t_power();
		t_rate();
		t_reset();
		complete_run();
	end
endmodule

`default_nettype wire
